// ===== src/cbx_map.vh
// Constants for the call, bound-check and bit-clear execution unit
`ifndef CBX_MAP_VH
`define CBX_MAP_VH

// Operation codes presented on op_code with op_start
`define CBX_OP_CALL_REL 4'h0
`define CBX_OP_CALL_REG 4'h1
`define CBX_OP_CALL_MEM_NEAR 4'h2
`define CBX_OP_CALL_FAR 4'h3
`define CBX_OP_CALL_MEM_FAR 4'h4
`define CBX_OP_VECTOR_CALL 4'h5
`define CBX_OP_BOUND_CHECK 4'h6
`define CBX_OP_BIT_CLEAR2 4'h7
`define CBX_OP_BIT_CLEAR1 4'h8
`define CBX_OP_INT_RETURN 4'h9

// Status word field positions
`define CBX_PSW_CARRY 0
`define CBX_PSW_BREAK 8
`define CBX_PSW_IE 9
`define CBX_PSW_DIR 10
`define CBX_PSW_MODE 15

// Bound trap vector table words (vector 5)
`define CBX_BOUND_PC_ADDR 16'h0014
`define CBX_BOUND_PS_ADDR 16'h0016

// Stack step in bytes and vector entry shift (four-byte entries)
`define CBX_STACK_STEP 16'h0002
`define CBX_VEC_SHIFT 2

// Push list slots
`define CBX_PUSH_PSW 2'h0
`define CBX_PUSH_PS 2'h1
`define CBX_PUSH_PC 2'h2

// Software register indices
`define CBX_REG_STATUS 2'h0
`define CBX_REG_CLEAR 2'h1
`define CBX_REG_ENABLE 2'h2
`define CBX_REG_STATE 2'h3

// Event bits
`define CBX_EV_TRAP 0
`define CBX_EV_VEC 1
`define CBX_EV_DONE 2
`define CBX_EV_RESET 3'h0

`endif

// ===== src/cbx_exec.v
// Call, vectored call, bound check, interrupt return and bit-clear execution unit
// What this block does
// (RULE_01) Relative call: push counter, add signed displacement
// (RULE_02) Register call: push counter, load from register
// (RULE_03) Near indirect: read offset, push, jump there
// (RULE_04) Direct far: push segment, counter; load both
// (RULE_05) Far indirect: read pointer, push, load both
// (RULE_06) Push: decrement stack by two, store word
// (RULE_07) Far forms save both; flags untouched
// (RULE_08) Vector call pushes status mode 0, segment, counter
// (RULE_09) Vector call sets mode, loads vector entry
// (RULE_10) Interrupt return restores status, counter, segment
// (RULE_11) Bound check reads lower, upper limit words
// (RULE_12) Out of range traps vector five
// (RULE_13) Trap loads counter 014H, segment 016H
// (RULE_14) In range: no flags, no pushes
// (RULE_15) Two-operand bit clear zeroes selected bit
// (RULE_16) Bit position masked to 3 or 4 bits
// (RULE_17) One-operand clear zeroes carry or direction
// (RULE_18) Displacement and return address use next instruction
// (RULE_19) Interrupts accepted only between instructions
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cbx_map.vh"

module cbx_exec #(
	parameter DW = 16
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire op_start,
	input wire [3:0] op_code,
	input wire [DW-1:0] op_next_pc,
	input wire [DW-1:0] op_a,
	input wire [DW-1:0] op_b,
	input wire [7:0] op_vector_number,
	input wire op_word,
	input wire op_sel_dir,
	input wire [DW-1:0] cpu_sp,
	input wire [DW-1:0] cpu_ps,
	input wire [DW-1:0] cpu_psw,
	output wire op_busy,
	output reg op_done,
	output reg [DW-1:0] pc_out,
	output reg [DW-1:0] ps_out,
	output reg [DW-1:0] sp_out,
	output reg [DW-1:0] psw_out,
	output reg [DW-1:0] result_out,
	output reg result_valid,
	output reg trap_taken,
	output wire irq_accept_ok,
	output reg mem_req,
	output reg mem_we,
	output reg [DW-1:0] mem_addr,
	output reg [DW-1:0] mem_wdata,
	input wire mem_ack,
	input wire [DW-1:0] mem_rdata,
	input wire [1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	output wire irq
);

	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_READ = 4'h2;
	localparam [3:0] S_PUSH = 4'h4;
	localparam [3:0] S_DONE = 4'h8;

	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	reg [3:0] op_ff;
	reg [DW-1:0] a_ff;
	reg [DW-1:0] b_ff;
	reg [DW-1:0] npc_ff;
	reg [7:0] vec_ff;
	reg word_ff;
	reg dir_ff;
	reg [DW-1:0] sp_ff;
	reg [DW-1:0] ps_ff;
	reg [DW-1:0] psw_ff;
	reg [DW-1:0] rw0_ff;
	reg [DW-1:0] rw1_ff;
	reg [DW-1:0] rw2_ff;
	reg [DW-1:0] rw3_ff;
	reg [2:0] rd_idx_ff;
	reg [1:0] push_idx_ff;
	reg out_of_range_ff;
	reg [2:0] status_ff;
	reg [2:0] enable_ff;

	reg [2:0] rd_count;
	reg [1:0] push_first;
	reg [DW-1:0] rd_addr;
	reg [DW-1:0] push_word;
	reg [DW-1:0] vec_base;
	reg [3:0] bit_pos;
	reg [DW-1:0] bit_mask;
	reg [DW-1:0] clr_result;
	wire bound_lo_fail;
	wire bound_hi_fail;
	wire [DW-1:0] sp_dec;
	reg [2:0] ev_set;

	assign op_busy = ~state_ff[0];
	// Only an idle unit with no new start lets an interrupt in
	assign irq_accept_ok = state_ff[0] & ~op_start; // see RULE_19
	assign irq = |(status_ff & enable_ff);
	assign sp_dec = sp_ff - `CBX_STACK_STEP; // see RULE_06

	// Signed index compare, as array bounds may straddle zero
	assign bound_lo_fail = $signed(b_ff) < $signed(rw0_ff); // see RULE_12
	// Upper limit is judged as it arrives on the bus, before rw1_ff holds it
	assign bound_hi_fail = $signed(b_ff) > $signed(mem_rdata); // see RULE_12

	always @* begin
		vec_base = {{(DW-10){1'b0}}, vec_ff, 2'b00}; // see RULE_09
		case (op_ff)
		`CBX_OP_CALL_MEM_NEAR: rd_count = 3'd1;
		`CBX_OP_CALL_MEM_FAR: rd_count = 3'd2;
		`CBX_OP_VECTOR_CALL: rd_count = 3'd2;
		`CBX_OP_BOUND_CHECK: rd_count = out_of_range_ff ? 3'd4 : 3'd2;
		`CBX_OP_INT_RETURN: rd_count = 3'd3;
		default: rd_count = 3'd0;
		endcase
		case (op_ff)
		`CBX_OP_CALL_FAR: push_first = `CBX_PUSH_PS; // see RULE_07
		`CBX_OP_CALL_MEM_FAR: push_first = `CBX_PUSH_PS; // see RULE_07
		`CBX_OP_VECTOR_CALL: push_first = `CBX_PUSH_PSW; // see RULE_08
		`CBX_OP_BOUND_CHECK: push_first = `CBX_PUSH_PSW; // see RULE_12
		default: push_first = `CBX_PUSH_PC;
		endcase
		case (rd_idx_ff)
		3'd0: begin
			if (op_ff == `CBX_OP_VECTOR_CALL)
				rd_addr = vec_base;
			else if (op_ff == `CBX_OP_INT_RETURN)
				rd_addr = sp_ff;
			else
				rd_addr = a_ff; // see RULE_03
		end
		3'd1: begin
			if (op_ff == `CBX_OP_VECTOR_CALL)
				rd_addr = vec_base + `CBX_STACK_STEP;
			else if (op_ff == `CBX_OP_INT_RETURN)
				rd_addr = sp_ff;
			else
				rd_addr = a_ff + `CBX_STACK_STEP; // see RULE_11
		end
		3'd2: begin
			if (op_ff == `CBX_OP_INT_RETURN)
				rd_addr = sp_ff;
			else
				rd_addr = `CBX_BOUND_PC_ADDR; // see RULE_13
		end
		default: rd_addr = `CBX_BOUND_PS_ADDR; // see RULE_13
		endcase
		case (push_idx_ff)
		`CBX_PUSH_PSW: begin
			push_word = psw_ff;
			// Status is saved with mode still recorded as emulation
			if (op_ff == `CBX_OP_VECTOR_CALL)
				push_word[`CBX_PSW_MODE] = 1'b0; // see RULE_08
		end
		`CBX_PUSH_PS: push_word = ps_ff;
		default: push_word = npc_ff; // see RULE_18
		endcase
		bit_pos = word_ff ? b_ff[3:0] : {1'b0, b_ff[2:0]}; // see RULE_16
		bit_mask = {{(DW-1){1'b0}}, 1'b1} << bit_pos;
		clr_result = a_ff & ~bit_mask; // see RULE_15
		if (!word_ff)
			clr_result[DW-1:8] = a_ff[DW-1:8];
	end

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
		S_IDLE: begin
			if (op_start)
				nxt_state = S_READ;
		end
		S_READ: begin
			if (rd_idx_ff >= rd_count) begin
				if (op_ff == `CBX_OP_INT_RETURN)
					nxt_state = S_DONE;
				else if (op_ff == `CBX_OP_BIT_CLEAR1 || op_ff == `CBX_OP_BIT_CLEAR2)
					nxt_state = S_DONE;
				else if (op_ff == `CBX_OP_BOUND_CHECK && !out_of_range_ff)
					nxt_state = S_DONE; // see RULE_14
				else
					nxt_state = S_PUSH;
			end
		end
		S_PUSH: begin
			if (mem_req && mem_ack && push_idx_ff == `CBX_PUSH_PC)
				nxt_state = S_DONE;
		end
		S_DONE: nxt_state = S_IDLE;
		default: nxt_state = S_IDLE;
		endcase
	end

	always @* begin
		ev_set = `CBX_EV_RESET;
		if (state_ff == S_DONE) begin
			ev_set[`CBX_EV_DONE] = 1'b1;
			ev_set[`CBX_EV_TRAP] = (op_ff == `CBX_OP_BOUND_CHECK) & out_of_range_ff;
			ev_set[`CBX_EV_VEC] = (op_ff == `CBX_OP_VECTOR_CALL);
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			state_ff <= S_IDLE;
			op_ff <= 4'h0;
			a_ff <= 16'h0000;
			b_ff <= 16'h0000;
			npc_ff <= 16'h0000;
			vec_ff <= 8'h00;
			word_ff <= 1'b0;
			dir_ff <= 1'b0;
			sp_ff <= 16'h0000;
			ps_ff <= 16'h0000;
			psw_ff <= 16'h0000;
			rw0_ff <= 16'h0000;
			rw1_ff <= 16'h0000;
			rw2_ff <= 16'h0000;
			rw3_ff <= 16'h0000;
			rd_idx_ff <= 3'h0;
			push_idx_ff <= 2'h0;
			out_of_range_ff <= 1'b0;
			op_done <= 1'b0;
			pc_out <= 16'h0000;
			ps_out <= 16'h0000;
			sp_out <= 16'h0000;
			psw_out <= 16'h0000;
			result_out <= 16'h0000;
			result_valid <= 1'b0;
			trap_taken <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 16'h0000;
		end else if (ce) begin
			state_ff <= nxt_state;
			op_done <= 1'b0;
			result_valid <= 1'b0;
			trap_taken <= 1'b0;
			case (state_ff)
			S_IDLE: begin
				if (op_start) begin
					op_ff <= op_code;
					a_ff <= op_a;
					b_ff <= op_b;
					npc_ff <= op_next_pc;
					vec_ff <= op_vector_number;
					word_ff <= op_word;
					dir_ff <= op_sel_dir;
					sp_ff <= cpu_sp;
					ps_ff <= cpu_ps;
					psw_ff <= cpu_psw;
					rd_idx_ff <= 3'h0;
					out_of_range_ff <= 1'b0;
				end
			end
			S_READ: begin
				if (rd_idx_ff < rd_count) begin
					if (!mem_req) begin
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_addr <= rd_addr;
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						rd_idx_ff <= rd_idx_ff + 3'd1;
						// Pops step the stack upward one word at a time
						if (op_ff == `CBX_OP_INT_RETURN)
							sp_ff <= sp_ff + `CBX_STACK_STEP; // see RULE_10
						case (rd_idx_ff)
						3'd0: rw0_ff <= mem_rdata;
						3'd1: rw1_ff <= mem_rdata;
						3'd2: rw2_ff <= mem_rdata;
						default: rw3_ff <= mem_rdata;
						endcase
						if (op_ff == `CBX_OP_BOUND_CHECK && rd_idx_ff == 3'd1) begin
							// Upper limit arrives now; lower already held
							out_of_range_ff <= bound_lo_fail | bound_hi_fail; // see RULE_12
						end
					end
				end else begin
					push_idx_ff <= push_first;
				end
			end
			S_PUSH: begin
				if (!mem_req) begin
					mem_req <= 1'b1;
					mem_we <= 1'b1;
					mem_addr <= sp_dec; // see RULE_06
					mem_wdata <= push_word;
				end else if (mem_ack) begin
					mem_req <= 1'b0;
					mem_we <= 1'b0;
					sp_ff <= sp_dec; // see RULE_06
					push_idx_ff <= push_idx_ff + 2'd1;
				end
			end
			S_DONE: begin
				op_done <= 1'b1;
				sp_out <= sp_ff;
				ps_out <= ps_ff;
				psw_out <= psw_ff; // see RULE_07
				pc_out <= npc_ff; // see RULE_14
				case (op_ff)
				`CBX_OP_CALL_REL: pc_out <= npc_ff + a_ff; // see RULE_01
				`CBX_OP_CALL_REG: pc_out <= a_ff; // see RULE_02
				`CBX_OP_CALL_MEM_NEAR: pc_out <= rw0_ff; // see RULE_03
				`CBX_OP_CALL_FAR: begin
					pc_out <= a_ff; // see RULE_04
					ps_out <= b_ff; // see RULE_04
				end
				`CBX_OP_CALL_MEM_FAR: begin
					pc_out <= rw0_ff; // see RULE_05
					ps_out <= rw1_ff; // see RULE_05
				end
				`CBX_OP_VECTOR_CALL: begin
					pc_out <= rw0_ff; // see RULE_09
					ps_out <= rw1_ff; // see RULE_09
					psw_out[`CBX_PSW_MODE] <= 1'b1; // see RULE_09
				end
				`CBX_OP_BOUND_CHECK: begin
					if (out_of_range_ff) begin
						pc_out <= rw2_ff; // see RULE_13
						ps_out <= rw3_ff; // see RULE_13
						psw_out[`CBX_PSW_IE] <= 1'b0; // see RULE_12
						psw_out[`CBX_PSW_BREAK] <= 1'b0; // see RULE_12
						trap_taken <= 1'b1;
					end
				end
				`CBX_OP_INT_RETURN: begin
					pc_out <= rw0_ff; // see RULE_10
					ps_out <= rw1_ff; // see RULE_10
					psw_out <= rw2_ff; // see RULE_10
				end
				`CBX_OP_BIT_CLEAR2: begin
					result_out <= clr_result; // see RULE_15
					result_valid <= 1'b1;
				end
				`CBX_OP_BIT_CLEAR1: begin
					if (dir_ff)
						psw_out[`CBX_PSW_DIR] <= 1'b0; // see RULE_17
					else
						psw_out[`CBX_PSW_CARRY] <= 1'b0; // see RULE_17
				end
				default: pc_out <= npc_ff;
				endcase
			end
			default: mem_req <= 1'b0;
			endcase
		end
	end

	// Software registers; a new event beats a clear in the same cycle
	always @(posedge clk) begin
		if (rst) begin
			status_ff <= `CBX_EV_RESET;
			enable_ff <= `CBX_EV_RESET;
			reg_rdata <= 8'h00;
		end else if (ce) begin
			if (reg_wr && reg_addr == `CBX_REG_CLEAR)
				status_ff <= (status_ff & ~reg_wdata[2:0]) | ev_set;
			else
				status_ff <= status_ff | ev_set;
			if (reg_wr && reg_addr == `CBX_REG_ENABLE)
				enable_ff <= reg_wdata[2:0];
			reg_rdata <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
				`CBX_REG_STATUS: reg_rdata <= {5'h00, status_ff};
				`CBX_REG_ENABLE: reg_rdata <= {5'h00, enable_ff};
				`CBX_REG_STATE: reg_rdata <= {3'h0, out_of_range_ff, state_ff};
				default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// ===== test/cbx_exec_chk.sv
// Port-level assertions for the call, bound-check and bit-clear unit
`timescale 1ns/1ps
`default_nettype none
module cbx_exec_chk #(
	parameter DW = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic op_start,
	input wire logic [3:0] op_code,
	input wire logic op_busy,
	input wire logic op_done,
	input wire logic result_valid,
	input wire logic trap_taken,
	input wire logic irq_accept_ok,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [DW-1:0] mem_addr,
	input wire logic mem_ack,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_done_pulse: assert property (op_done |=> !op_done)
		else $error("done pulse too long");
	a_flag_pair: assert property ((result_valid || trap_taken) |-> op_done)
		else $error("result or trap flag without done");
	a_start_busy: assert property (ce && op_start && !op_busy |=> op_busy)
		else $error("start not taken");
	a_accept_idle: assert property (irq_accept_ok |-> !op_busy && !op_start)
		else $error("interrupt window inside an operation");
	a_req_in_op: assert property (mem_req |-> op_busy)
		else $error("memory access outside an operation");
	a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
		&& $stable(mem_we)) else $error("request changed before ack");
	a_req_gap: assert property (mem_req && mem_ack |=> !mem_req)
		else $error("no idle cycle after ack");
	a_push_step: assert property (mem_req && mem_we && mem_ack ##2 mem_req && mem_we
		|-> mem_addr == $past(mem_addr, 2) - 16'h2)
		else $error("push address step wrong");
	a_clear_time: assert property (ce && op_start && !op_busy && (op_code == 4'h7
		|| op_code == 4'h8) |=> !op_done ##1 !op_done ##1 op_done)
		else $error("bit clear latency wrong");
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h0)
		else $error("read data outside read cycle");
endmodule
bind cbx_exec cbx_exec_chk #(.DW(DW)) u_chk (.*);
`default_nettype wire

// ===== test/cbx_mem.sv
// Memory model holding code, stack and vector table
`timescale 1ns/1ps
`default_nettype none
module cbx_mem (
	input wire logic clk,
	input wire logic [3:0] dly,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	logic [7:0] m [0:65535];
	logic [3:0] cnt = 4'h0;
	initial mem_ack = 1'b0;
	initial mem_rdata = 16'h0;
	// Read data toggle outside ack so a stale word never looks valid
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (cnt == dly) begin
				cnt <= 4'h0;
				mem_ack <= 1'b1;
				if (mem_we) begin
					m[mem_addr] <= mem_wdata[7:0];
					m[mem_addr + 16'h1] <= mem_wdata[15:8];
				end else
					mem_rdata <= {m[mem_addr + 16'h1], m[mem_addr]};
			end else
				cnt <= cnt + 4'h1;
		end else
			// A request dropped mid-wait must not leave a stale count behind
			cnt <= 4'h0;
	end
endmodule
`default_nettype wire

// ===== test/tb_call_bound_check_exec.sv
// Self-checking bench for the call, bound-check and bit-clear unit
`timescale 1ns/1ps
`default_nettype none
module tb_call_bound_check_exec;
	typedef struct {
		logic [3:0] op;
		logic [15:0] a, b;
		logic [7:0] v;
		logic w, d, t;
		logic [15:0] pc, ps, sp, sw, rs;
	} cbx_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic op_start = 1'b0, op_word = 1'b0, op_sel_dir = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] op_code = 4'h0, dly = 4'h0;
	logic [15:0] op_a = 16'h0, op_b = 16'h0;
	logic [7:0] op_vector_number = 8'h0, reg_wdata = 8'h0;
	logic [1:0] reg_addr = 2'h0;
	wire op_busy, op_done, result_valid, trap_taken, irq_accept_ok, mem_req, mem_we, mem_ack, irq;
	wire [15:0] pc_out, ps_out, sp_out, psw_out, result_out, mem_addr, mem_wdata, mem_rdata;
	wire [7:0] reg_rdata;
	int fail_count = 0, checks_done = 0;
	logic [15:0] stk [3] = '{16'h0707, 16'h2000, 16'h0105};
	cbx_row_t rows [14];
	always #12.5 clk = ~clk;
	// Emulation-mode context: status word has the mode flag clear
	cbx_exec dut (.ce(ce), .op_next_pc(16'h0105), .cpu_sp(16'h1000), .cpu_ps(16'h2000),
		.cpu_psw(16'h0707), .*);
	cbx_mem u_mem (.*);
	task automatic close_out;
		if (fail_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic put(input logic [15:0] a, input logic [15:0] w);
		u_mem.m[a] = w[7:0];
		u_mem.m[a + 16'h1] = w[15:8];
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg", {8'h0, reg_rdata}, {8'h0, e});
	endtask
	task automatic run(input cbx_row_t r);
		int i;
		int n;
		logic [15:0] w;
		for (i = 0; i < 3; i++)
			put(16'h0FFA + 16'(2 * i), 16'hEEEE);
		@(posedge clk);
		op_code <= r.op;
		op_a <= r.a;
		op_b <= r.b;
		op_vector_number <= r.v;
		op_word <= r.w;
		op_sel_dir <= r.d;
		op_start <= 1'b1;
		@(posedge clk);
		op_start <= 1'b0;
		#1;
		chk("busy", 16'(op_busy), 16'h1);
		chk("accept", 16'(irq_accept_ok), 16'h0);
		i = 0;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (op_done !== 1'b1 && i < 300);
		if (op_done !== 1'b1) begin
			fail_count++;
			close_out();
		end
		chk("pc", pc_out, r.pc);
		chk("ps", ps_out, r.ps);
		chk("sp", sp_out, r.sp);
		chk("psw", psw_out, r.sw);
		chk("trap", 16'(trap_taken), 16'(r.t));
		chk("valid", 16'(result_valid), 16'(r.op == 4'h7));
		if (r.op == 4'h7)
			chk("result", result_out, r.rs);
		n = (r.sp < 16'h1000) ? (16'h1000 - r.sp) / 2 : 0;
		for (i = 1; i <= n; i++) begin
			w = {u_mem.m[16'h1001 - 16'(2 * i)], u_mem.m[16'h1000 - 16'(2 * i)]};
			chk("stack", w, stk[2 - n + i]);
		end
		if (n == 0)
			chk("stack", {u_mem.m[16'h0FFF], u_mem.m[16'h0FFE]}, 16'hEEEE);
	endtask
	initial begin
		int j;
		rows = '{
			'{4'h0, 16'hFFF0, 16'h0, 8'h0, 0, 0, 0, 16'hF5, 16'h2000, 16'hFFE, 16'h707, 16'h0},
			'{4'h1, 16'h1234, 16'h0, 8'h0, 0, 0, 0, 16'h1234, 16'h2000, 16'hFFE, 16'h707, 16'h0},
			'{4'h2, 16'h300, 16'h0, 8'h0, 0, 0, 0, 16'h4455, 16'h2000, 16'hFFE, 16'h707, 16'h0},
			'{4'h3, 16'hABCD, 16'h5678, 8'h0, 0, 0, 0, 16'hABCD, 16'h5678, 16'hFFC, 16'h707, 16'h0},
			'{4'h4, 16'h310, 16'h0, 8'h0, 0, 0, 0, 16'h1111, 16'h2222, 16'hFFC, 16'h707, 16'h0},
			'{4'h5, 16'h0, 16'h0, 8'h40, 0, 0, 0, 16'h3333, 16'h4444, 16'hFFA, 16'h8707, 16'h0},
			'{4'h6, 16'h320, 16'h20, 8'h0, 0, 0, 0, 16'h105, 16'h2000, 16'h1000, 16'h707, 16'h0},
			'{4'h6, 16'h320, 16'hFFFF, 8'h0, 0, 0, 1, 16'h5555, 16'h6666, 16'hFFA, 16'h407, 16'h0},
			'{4'h6, 16'h320, 16'h21, 8'h0, 0, 0, 1, 16'h5555, 16'h6666, 16'hFFA, 16'h407, 16'h0},
			'{4'h7, 16'hFFFF, 16'h13, 8'h0, 1, 0, 0, 16'h105, 16'h2000, 16'h1000, 16'h707, 16'hFFF7},
			'{4'h7, 16'hFFFF, 16'hF, 8'h0, 0, 0, 0, 16'h105, 16'h2000, 16'h1000, 16'h707, 16'hFF7F},
			'{4'h8, 16'h0, 16'h0, 8'h0, 0, 0, 0, 16'h105, 16'h2000, 16'h1000, 16'h706, 16'h0},
			'{4'h8, 16'h0, 16'h0, 8'h0, 0, 1, 0, 16'h105, 16'h2000, 16'h1000, 16'h307, 16'h0},
			'{4'h9, 16'h0, 16'h0, 8'h0, 0, 0, 0, 16'h7777, 16'h8888, 16'h1006, 16'h203, 16'h0}};
		put(16'h300, 16'h4455);
		put(16'h310, 16'h1111);
		put(16'h312, 16'h2222);
		put(16'h100, 16'h3333);
		put(16'h102, 16'h4444);
		put(16'h14, 16'h5555);
		put(16'h16, 16'h6666);
		put(16'h320, 16'h10);
		put(16'h322, 16'h20);
		put(16'h1000, 16'h7777);
		put(16'h1002, 16'h8888);
		put(16'h1004, 16'h203);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("accept", 16'(irq_accept_ok), 16'h1);
		// Second pass repeats every row against a slow memory
		for (j = 0; j < 28; j++) begin
			dly <= (j < 14) ? 4'h0 : 4'h3;
			run(rows[j % 14]);
		end
		chk("irq", 16'(irq), 16'h0);
		rd(2'h0, 8'h07);
		wr(2'h2, 8'h02);
		chk("irq", 16'(irq), 16'h1);
		rd(2'h2, 8'h02);
		wr(2'h0, 8'hFF);
		rd(2'h0, 8'h07);
		rd(2'h1, 8'h00);
		wr(2'h1, 8'h02);
		chk("irq", 16'(irq), 16'h0);
		rd(2'h0, 8'h05);
		rd(2'h3, 8'h01);
		// Clock enable low must freeze the read port as well
		@(posedge clk);
		ce <= 1'b0;
		reg_addr <= 2'h0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		ce <= 1'b1;
		#1;
		chk("frozen", {8'h0, reg_rdata}, 16'h0000);
		@(posedge clk);
		dly <= 4'h7;
		op_code <= 4'h3;
		op_start <= 1'b1;
		@(posedge clk);
		op_start <= 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		rst <= 1'b0;
		#1;
		chk("busy", 16'(op_busy), 16'h0);
		chk("req", 16'(mem_req), 16'h0);
		rd(2'h0, 8'h00);
		run(rows[7]);
		close_out();
	end
endmodule
`default_nettype wire
